// [rtl/uar_defines.svh]
/*
 * Constants of the asynchronous serial receiver: oversampling figures,
 * bit-rate multipliers, character sizes, queue depth and reset values.
 * Assumes it is included by its bare name; it holds definitions only.
 */
`ifndef UAR_DEFINES_SVH
`define UAR_DEFINES_SVH

// line recovery runs at this many ticks per bit period
`define UAR_OVERSAMPLE 16
// tick indices within a bit period that feed the majority vote
`define UAR_VOTE_FIRST 4'h7
`define UAR_VOTE_LAST 4'h9

// oscillator periods per bit, per unit of divisor plus one
`define UAR_LOW_SPEED_MULT 64
`define UAR_HIGH_SPEED_MULT 16
`define UAR_DIVISOR_W 8
`define UAR_PRESCALE_W 10

// data bits per character
`define UAR_DATA_BITS_8 4'h8
`define UAR_DATA_BITS_9 4'h9

// receive queue depth
`define UAR_FIFO_DEPTH 2

// reset values
`define UAR_RESET_DATA 8'h00

`endif

// [rtl/uar_pkg.sv]
/*
 * Types shared by the serial receiver and its receive queue.
 * Assumes uar_defines.svh is on the include path.
 */
`include "uar_defines.svh"

package uar_pkg;

    // receiver sequencer states
    typedef enum logic [1:0]
    {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10,
        RX_STOP = 2'b11
    } uar_rx_state_t;

    // one queue entry: nine data bits and its framing error
    typedef struct packed
    {
        logic [8:0] data;
        logic frameErr;
    } uar_entry_t;

    // complete state of the receiver top
    typedef struct packed
    {
        uar_rx_state_t state;
        logic [`UAR_PRESCALE_W-1:0] preCnt;
        logic [3:0] tickCnt;
        logic [3:0] bitCnt;
        logic [1:0] vote;
        logic [8:0] shift;
        logic lineMeta;
        logic lineSync;
        logic linePrev;
        logic overrun;
        logic [7:0] rxData;
        logic ninth;
        logic frameErr;
        logic ready;
        logic irq;
        logic rxOe;
        logic txOe;
    } uar_rx_regs_t;

endpackage

// [rtl/uar_rx_fifo_if.sv]
/*
 * Interface between the receiver sequencer and its receive queue.
 * Assumes both ends run on the same clock and clock enable.
 */
`timescale 1ns/100ps
`default_nettype none
`include "uar_defines.svh"

interface uar_rx_fifo_if;
    logic push;
    logic pop;
    logic flush;
    uar_pkg::uar_entry_t pushEntry;
    uar_pkg::uar_entry_t headEntry;
    logic full;
    logic notEmpty;

    modport producer
    (
        output push, pop, flush, pushEntry,
        input headEntry, full, notEmpty
    );

    modport store
    (
        input push, pop, flush, pushEntry,
        output headEntry, full, notEmpty
    );
endinterface

`default_nettype wire

// [rtl/uar_rx_fifo.sv]
/*
 * Receive queue of the serial receiver: a small first-in first-out
 * store of characters, each with its framing error bit.
 * Assumes the producer never pushes into a full queue unless it pops
 * in the same cycle; such a push is dropped here as well.
 */
`timescale 1ns/100ps
`default_nettype none
`include "uar_defines.svh"

module uar_rx_fifo
#(
    parameter int DEPTH = `UAR_FIFO_DEPTH
)
(
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clkEn,
    // queue access
    uar_rx_fifo_if.store fif
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    // pointers wrap by overflow, so the depth must be a power of two
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_depthCheck
        $error("uar_rx_fifo: DEPTH must be a power of two, at least 2");
    end

    typedef struct packed
    {
        uar_pkg::uar_entry_t [DEPTH-1:0] mem;
        logic [PW-1:0] rdPtr;
        logic [PW-1:0] wrPtr;
        logic [CW-1:0] count;
    } uar_fifo_regs_t;

    uar_fifo_regs_t r;
    uar_fifo_regs_t n;
    logic doPop;
    logic doPush;

    // pop frees a slot in the same cycle, so a full queue may still take one
    always_comb
    begin
        n = r;
        doPop = fif.pop && (r.count != '0);
        doPush = fif.push && ((r.count != CW'(DEPTH)) || doPop);
        if (doPop)
        begin
            n.rdPtr = r.rdPtr + PW'(1);
        end
        if (doPush)
        begin
            n.mem[r.wrPtr] = fif.pushEntry;
            n.wrPtr = r.wrPtr + PW'(1);
        end
        n.count = r.count + CW'(doPush) - CW'(doPop);
        if (fif.flush)
        begin
            n.rdPtr = '0;
            n.wrPtr = '0;
            n.count = '0;
        end
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            r <= '0;
        end
        else if (clkEn)
        begin
            r <= n;
        end
    end

    assign fif.headEntry = r.mem[r.rdPtr];
    assign fif.full = (r.count == CW'(DEPTH));
    assign fif.notEmpty = (r.count != '0);
endmodule

`default_nettype wire

// [rtl/uar_async_receiver.sv]
/*
 * Asynchronous serial receiver: start-bit search, sixteen-fold
 * oversampling with majority vote, eight or nine bit characters,
 * a two-entry receive queue with framing error per entry, overrun
 * and nine-bit address filtering.
 * Assumes control bits arrive on the same clock; only the receive pin
 * is asynchronous. The bit-rate divisor is the rate register's value.
 */
// Summary of operation
// - line recovery oversamples at sixteen ticks per bit; shifter advances per bit
// - a complete character moves at once into a two-entry receive queue
// - falling edge starts; half a bit later a high line drops silently
// - each following bit sampled one bit period later by majority vote
// - stop position sampled; low marks framing error, high clears it
// - after stop the character is queued; a data read pops oldest entry
// - ready flag high exactly while receiver enabled and queue non-empty
// - interrupt request needs receive, peripheral and global enables plus ready
// - each entry keeps its framing error; status follows the oldest entry
// - framing status read-only, forced low by port disable, kept by receive disable
// - framing-error characters are queued and reception carries on
// - third character into full queue sets overrun and stops reception
// - overrun cleared only by clearing receive enable or port enable
// - nine-bit mode shifts nine bits; ninth bit of oldest entry shown
// - address detect in nine-bit mode queues only ninth-bit-set characters
// - receiver runs with receive on, synchronous off, port on; pins forced
// - characters arrive least significant bit first in one shared format
// - high-speed select picks sixteen or sixty-four periods per divisor step
// - port disabled holds the serial unit in reset
`timescale 1ns/100ps
`default_nettype none
`include "uar_defines.svh"

module uar_async_receiver
#(
    parameter int FIFO_DEPTH = `UAR_FIFO_DEPTH
)
(
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clkEn,
    // serial line
    input wire logic serialReceivePin,
    // control bits
    input wire logic serialPortEnable,
    input wire logic continuousReceiveEnable,
    input wire logic syncModeSelect,
    input wire logic nineBitReceiveSelect,
    input wire logic addressDetectEnable,
    input wire logic highSpeedRateSelect,
    input wire logic [`UAR_DIVISOR_W-1:0] rateDivisor,
    input wire logic receiveDataRead,
    // interrupt enables
    input wire logic receiveInterruptEnable,
    input wire logic peripheralInterruptEnable,
    input wire logic globalInterruptEnable,
    // pin direction settings, high means input
    input wire logic rxPinDirectionSetting,
    input wire logic txPinDirectionSetting,
    // received character and status
    output logic [7:0] receiveData,
    output logic receivedNinthBit,
    output logic framingErrorStatus,
    output logic overrunErrorFlag,
    output logic receiveReadyFlag,
    output logic receiveIrq,
    // pin output enables
    output logic rxPinOutEn,
    output logic txPinOutEn
);
    localparam int PW = `UAR_PRESCALE_W;

    // fewer than two entries could not hold the pair of waiting characters
    if (FIFO_DEPTH < 2)
    begin : g_depthCheck
        $error("uar_async_receiver: FIFO_DEPTH must be at least 2");
    end

    // two of three agree
    function automatic logic majority(input logic [2:0] v);
        majority = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction

    uar_rx_fifo_if fif ();

    uar_rx_fifo #(.DEPTH(FIFO_DEPTH)) u_fifo
    (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .clkEn(clkEn),
        .fif(fif)
    );

    uar_pkg::uar_rx_regs_t r;
    uar_pkg::uar_rx_regs_t n;
    logic [PW-1:0] tickLimit;
    logic [PW-1:0] tickScale;
    logic tick;
    logic evalNow;
    logic bitVal;
    logic rxEnable;
    logic readyCalc;
    logic accept;
    logic room;
    logic stopEval;
    logic [3:0] dataBits;

    // bit-rate tick: one tick every scale*(divisor+1) clocks
    always_comb
    begin
        tickScale = highSpeedRateSelect ?
            PW'(`UAR_HIGH_SPEED_MULT / `UAR_OVERSAMPLE) :
            PW'(`UAR_LOW_SPEED_MULT / `UAR_OVERSAMPLE);
        tickLimit = PW'(({2'b00, rateDivisor} + PW'(1)) * tickScale - PW'(1));
        tick = (r.preCnt == tickLimit);
    end

    // vote uses the two stored ticks and the live third one
    assign evalNow = tick && (r.tickCnt == `UAR_VOTE_LAST);
    assign bitVal = majority({r.vote, r.lineSync});
    assign rxEnable = serialPortEnable && continuousReceiveEnable && !syncModeSelect;
    assign dataBits = nineBitReceiveSelect ? `UAR_DATA_BITS_9 : `UAR_DATA_BITS_8;
    assign stopEval = evalNow && (r.state == uar_pkg::RX_STOP);
    // a non-address character is thrown away while filtering
    assign accept = !(addressDetectEnable && nineBitReceiveSelect && !r.shift[8]);
    assign room = !fif.full || fif.pop;
    assign readyCalc = rxEnable && fif.notEmpty;

    // next-state logic of the whole receiver
    always_comb
    begin
        n = r;
        fif.push = 1'b0;
        fif.pushEntry = '0;
        fif.pop = receiveDataRead && serialPortEnable;
        fif.flush = !serialPortEnable;
        // receive pin is asynchronous: two flops before any use
        n.lineMeta = serialReceivePin;
        n.lineSync = r.lineMeta;
        n.linePrev = r.lineSync;
        n.preCnt = tick ? '0 : r.preCnt + PW'(1);
        if (tick)
        begin
            n.tickCnt = r.tickCnt + 4'h1;
            if (r.tickCnt >= `UAR_VOTE_FIRST && r.tickCnt < `UAR_VOTE_LAST)
            begin
                n.vote = {r.vote[0], r.lineSync};
            end
        end
        unique case (r.state)
            uar_pkg::RX_IDLE:
            begin
                // falling edge while allowed to receive
                if (rxEnable && !r.overrun && r.linePrev && !r.lineSync)
                begin
                    n.state = uar_pkg::RX_START;
                    n.preCnt = '0;
                    n.tickCnt = '0;
                end
            end
            uar_pkg::RX_START:
            begin
                if (evalNow)
                begin
                    n.bitCnt = '0;
                    n.state = bitVal ? uar_pkg::RX_IDLE : uar_pkg::RX_DATA;
                end
            end
            uar_pkg::RX_DATA:
            begin
                if (evalNow)
                begin
                    // least significant bit first: shift in from the top
                    n.shift = {bitVal, r.shift[8:1]};
                    n.bitCnt = r.bitCnt + 4'h1;
                    if (r.bitCnt + 4'h1 == dataBits)
                    begin
                        n.state = uar_pkg::RX_STOP;
                    end
                end
            end
            uar_pkg::RX_STOP:
            begin
                if (evalNow)
                begin
                    n.state = uar_pkg::RX_IDLE;
                    if (!nineBitReceiveSelect)
                    begin
                        n.shift = {1'b0, r.shift[8:1]};
                    end
                end
            end
        endcase
        // stop sample: queue the character, or flag overrun on a full queue
        if (stopEval && accept && rxEnable)
        begin
            fif.pushEntry.data = nineBitReceiveSelect ? r.shift : {1'b0, r.shift[8:1]};
            fif.pushEntry.frameErr = !bitVal;
            if (room)
            begin
                fif.push = 1'b1;
            end
            else
            begin
                n.overrun = 1'b1;
            end
        end
        // receive disable aborts a character and clears overrun
        if (!rxEnable)
        begin
            n.state = uar_pkg::RX_IDLE;
        end
        if (!continuousReceiveEnable || !serialPortEnable)
        begin
            n.overrun = 1'b0;
        end
        if (!serialPortEnable)
        begin
            n.preCnt = '0;
            n.tickCnt = '0;
            n.bitCnt = '0;
        end
        // status reflects the oldest unread entry
        n.rxData = fif.headEntry.data[7:0];
        n.ninth = fif.headEntry.data[8];
        n.frameErr = fif.headEntry.frameErr && fif.notEmpty && serialPortEnable;
        n.ready = readyCalc;
        n.irq = readyCalc && receiveInterruptEnable && peripheralInterruptEnable
            && globalInterruptEnable;
        // port enable overrides the pin direction settings
        n.txOe = serialPortEnable || !txPinDirectionSetting;
        n.rxOe = !serialPortEnable && !rxPinDirectionSetting;
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            r <= '0;
            r.rxData <= `UAR_RESET_DATA;
            r.lineMeta <= 1'b1;
            r.lineSync <= 1'b1;
            r.linePrev <= 1'b1;
        end
        else if (clkEn)
        begin
            r <= n;
        end
    end

    // every output is a flop of the state struct
    assign receiveData = r.rxData;
    assign receivedNinthBit = r.ninth;
    assign framingErrorStatus = r.frameErr;
    assign overrunErrorFlag = r.overrun;
    assign receiveReadyFlag = r.ready;
    assign receiveIrq = r.irq;
    assign rxPinOutEn = r.rxOe;
    assign txPinOutEn = r.txOe;

    // checks on the live design
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    // ready follows enables and queue occupancy, spelled out independently
    ready_flag_a: assert property (clkEn |=> receiveReadyFlag ==
        $past(serialPortEnable && continuousReceiveEnable && !syncModeSelect && fif.notEmpty))
        else $error("ready flag does not follow enable and queue state");

    irq_gate_a: assert property (clkEn |=> receiveIrq == (receiveReadyFlag
        && $past(receiveInterruptEnable) && $past(peripheralInterruptEnable)
        && $past(globalInterruptEnable)))
        else $error("interrupt request not gated by all enables");

    port_reset_a: assert property (clkEn && !serialPortEnable |=> !framingErrorStatus
        && !overrunErrorFlag && r.state == uar_pkg::RX_IDLE)
        else $error("port disable did not reset the receiver");

    overrun_clear_a: assert property (clkEn && !continuousReceiveEnable
        |=> !overrunErrorFlag)
        else $error("overrun not cleared by receive disable");

    overrun_hold_a: assert property (overrunErrorFlag && serialPortEnable
        && continuousReceiveEnable |=> overrunErrorFlag)
        else $error("overrun cleared without a disable");

    overrun_set_a: assert property (clkEn && stopEval && accept && rxEnable && !room
        |=> overrunErrorFlag && !$past(fif.push))
        else $error("full queue did not raise overrun");

    overrun_block_a: assert property (r.overrun && r.state == uar_pkg::RX_IDLE
        |-> !fif.push ##1 r.state == uar_pkg::RX_IDLE)
        else $error("reception continued during overrun");

    false_start_a: assert property (clkEn && r.state == uar_pkg::RX_START && evalNow
        && bitVal |=> r.state == uar_pkg::RX_IDLE && !fif.push)
        else $error("false start bit not dropped");

    addr_filter_a: assert property (fif.push && addressDetectEnable
        && nineBitReceiveSelect |-> fif.pushEntry.data[8])
        else $error("address filter passed a data character");

    stop_frame_a: assert property (fif.push |-> fif.pushEntry.frameErr == !bitVal
        && stopEval)
        else $error("framing error does not match stop sample");

    pin_dir_a: assert property (clkEn && serialPortEnable
        |=> txPinOutEn && !rxPinOutEn)
        else $error("port enable did not force pin directions");

    overrun_seen_c: cover property (clkEn && stopEval && accept && rxEnable && !room);
    frame_err_c: cover property (fif.push && fif.pushEntry.frameErr);
    addr_drop_c: cover property (stopEval && !accept && rxEnable);
    nine_bit_c: cover property (fif.push && nineBitReceiveSelect && fif.pushEntry.data[8]);
endmodule

`default_nettype wire

// [test/uar_line_tx.sv]
/*
 * Far-side serial transmitter model that frames characters onto the line.
 * Assumes the bench calls its tasks one at a time; the line idles high.
 */
`timescale 1ns/100ps
`default_nettype none

module uar_line_tx
(
    // clock
    input wire logic ref_clk,
    // serial line
    output logic line
);
    // idle high so the receiver sees no false edge after reset
    initial line = 1'b1;

    // one frame: start, data lsb first, stop at the chosen level, one idle bit
    task automatic send(input logic [8:0] d, input int nBits, input logic stopLvl,
        input int bitClk, input logic spike);
        int i;
        @(negedge ref_clk);
        line = 1'b0;
        repeat (bitClk) @(negedge ref_clk);
        for (i = 0; i < nBits; i++)
        begin
            line = d[i];
            // a one-clock spike on the middle vote sample must lose the vote;
            // the receiver sees the pin three clocks late through its flop chain
            if (spike)
            begin
                repeat (bitClk / 2 + 1) @(negedge ref_clk);
                line = ~d[i];
                @(negedge ref_clk);
                line = d[i];
                repeat (bitClk / 2 - 2) @(negedge ref_clk);
            end
            else
                repeat (bitClk) @(negedge ref_clk);
        end
        line = stopLvl;
        repeat (bitClk) @(negedge ref_clk);
        line = 1'b1;
        repeat (bitClk) @(negedge ref_clk);
    endtask

    // short low pulse, gone before the start-bit centre
    task automatic glitch(input int n);
        line = 1'b0;
        repeat (n) @(negedge ref_clk);
        line = 1'b1;
    endtask
endmodule

`default_nettype wire

// [test/uar_async_receiver_tb_top.sv]
/*
 * Self-checking bench of the asynchronous serial receiver.
 * Assumes the receiver and the transmitter model share ref_clk.
 */
`timescale 1ns/100ps
`default_nettype none

module uar_async_receiver_tb_top;
    localparam int BIT = 16;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic line;
    logic portEn = 1'b1, rxEn = 1'b1, sync = 1'b0, nine = 1'b0, addrEn = 1'b0;
    logic hs = 1'b1, rd = 1'b0, rie = 1'b0, pie = 1'b0, globIe = 1'b0;
    logic rxDir = 1'b1, txDir = 1'b1;
    logic [7:0] div = 8'h00;
    logic [7:0] rxData;
    logic ninth, frmErr, ovr, rdy, irq, rxOe, txOe;
    int miscompares = 0;
    int totalChecks = 0;

    // 20 MHz clock
    initial forever #25 ref_clk = ~ref_clk;

    uar_line_tx tx (.ref_clk(ref_clk), .line(line));

    // clock enable held high: every scenario runs at full rate
    uar_async_receiver dut
    (
        .ref_clk(ref_clk), .nrst(nrst), .clkEn(1'b1), .serialReceivePin(line),
        .serialPortEnable(portEn), .continuousReceiveEnable(rxEn), .syncModeSelect(sync),
        .nineBitReceiveSelect(nine), .addressDetectEnable(addrEn),
        .highSpeedRateSelect(hs), .rateDivisor(div), .receiveDataRead(rd),
        .receiveInterruptEnable(rie), .peripheralInterruptEnable(pie),
        .globalInterruptEnable(globIe), .rxPinDirectionSetting(rxDir),
        .txPinDirectionSetting(txDir), .receiveData(rxData), .receivedNinthBit(ninth),
        .framingErrorStatus(frmErr), .overrunErrorFlag(ovr), .receiveReadyFlag(rdy),
        .receiveIrq(irq), .rxPinOutEn(rxOe), .txPinOutEn(txOe)
    );

    // final counts and verdict
    task automatic summarize();
        $display("checks %0d mismatches %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // compare one value, four-state exact
    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        totalChecks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // bounded wait for the ready flag; a hang ends the run
    task automatic waitRdy();
        int n;
        n = 0;
        while (rdy !== 1'b1 && n < 40)
        begin
            @(negedge ref_clk);
            n++;
        end
        if (rdy !== 1'b1)
        begin
            miscompares++;
            $display("unexpected at %0t: ready %h expected 1", $time, rdy);
            summarize();
        end
    endtask

    // status is read before the data pulse, since the pulse pops
    task automatic head(input logic [8:0] d, input logic fe);
        check({ninth, rxData}, d);
        check(frmErr, fe);
        check(rdy, 1'b1);
    endtask

    task automatic pop();
        rd = 1'b1;
        @(negedge ref_clk);
        rd = 1'b0;
        repeat (3) @(negedge ref_clk);
    endtask

    // plain character, interrupt gating by each enable
    task automatic tBasic();
        int k;
        {rie, pie, globIe} = 3'b111;
        tx.send(9'h0a5, 8, 1'b1, BIT, 1'b0);
        waitRdy();
        head(9'h0a5, 1'b0);
        check(irq, 1'b1);
        for (k = 0; k < 3; k++)
        begin
            {rie, pie, globIe} = 3'b111 ^ (3'b001 << k);
            repeat (2) @(negedge ref_clk);
            check(irq, 1'b0);
            check(rdy, 1'b1);
        end
        {rie, pie, globIe} = 3'b111;
        pop();
        check(rdy, 1'b0);
        check(irq, 1'b0);
        $display("test basic done");
    endtask

    // per-entry framing error, overrun, blocking and its clearing
    task automatic tOverrun();
        tx.send(9'h03c, 8, 1'b1, BIT, 1'b0);
        tx.send(9'h0c3, 8, 1'b0, BIT, 1'b0);
        tx.send(9'h05a, 8, 1'b1, BIT, 1'b0);
        check(ovr, 1'b1);
        head(9'h03c, 1'b0);
        pop();
        head(9'h0c3, 1'b1);
        pop();
        check(rdy, 1'b0);
        tx.send(9'h0f0, 8, 1'b1, BIT, 1'b0);
        check(rdy, 1'b0);
        check(ovr, 1'b1);
        rxEn = 1'b0;
        repeat (2) @(negedge ref_clk);
        check(ovr, 1'b0);
        rxEn = 1'b1;
        tx.send(9'h081, 8, 1'b1, BIT, 1'b0);
        waitRdy();
        head(9'h081, 1'b0);
        pop();
        $display("test overrun done");
    endtask

    // short low pulse dropped; a centre spike outvoted
    task automatic tStart();
        tx.glitch(4);
        repeat (2 * BIT) @(negedge ref_clk);
        check(rdy, 1'b0);
        check(frmErr, 1'b0);
        tx.send(9'h07e, 8, 1'b1, BIT, 1'b1);
        waitRdy();
        head(9'h07e, 1'b0);
        pop();
        check(rdy, 1'b0);
        $display("test start done");
    endtask

    // nine-bit characters with address filtering
    task automatic tNine();
        nine = 1'b1;
        addrEn = 1'b1;
        tx.send(9'h0a5, 9, 1'b1, BIT, 1'b0);
        check(rdy, 1'b0);
        tx.send(9'h1a5, 9, 1'b1, BIT, 1'b0);
        waitRdy();
        head(9'h1a5, 1'b0);
        pop();
        addrEn = 1'b0;
        tx.send(9'h033, 9, 1'b1, BIT, 1'b0);
        waitRdy();
        head(9'h033, 1'b0);
        pop();
        nine = 1'b0;
        $display("test nine done");
    endtask

    // low-speed multiplier with divisor one: 128 clocks per bit
    task automatic tSlow();
        hs = 1'b0;
        div = 8'h01;
        tx.send(9'h096, 8, 1'b1, 128, 1'b0);
        waitRdy();
        head(9'h096, 1'b0);
        pop();
        hs = 1'b1;
        div = 8'h00;
        $display("test slow done");
    endtask

    // receive disable, sync mode, port disable and pin directions
    task automatic tPort();
        tx.send(9'h011, 8, 1'b0, BIT, 1'b0);
        waitRdy();
        check(frmErr, 1'b1);
        rxEn = 1'b0;
        repeat (3) @(negedge ref_clk);
        check(rdy, 1'b0);
        check(frmErr, 1'b1);
        rxEn = 1'b1;
        sync = 1'b1;
        repeat (3) @(negedge ref_clk);
        check(rdy, 1'b0);
        sync = 1'b0;
        repeat (3) @(negedge ref_clk);
        check(rdy, 1'b1);
        check({rxOe, txOe}, 2'b01);
        {rxDir, txDir} = 2'b00;
        portEn = 1'b0;
        repeat (3) @(negedge ref_clk);
        check(frmErr, 1'b0);
        check(rdy, 1'b0);
        check({rxOe, txOe}, 2'b11);
        portEn = 1'b1;
        repeat (3) @(negedge ref_clk);
        check({rxOe, txOe}, 2'b01);
        check(rdy, 1'b0);
        {rxDir, txDir} = 2'b11;
        $display("test port done");
    endtask

    // reset, then the scenarios in turn
    initial
    begin
        repeat (2) @(negedge ref_clk);
        nrst = 1'b1;
        repeat (4) @(negedge ref_clk);
        check(rdy, 1'b0);
        tBasic();
        tOverrun();
        tStart();
        tNine();
        tSlow();
        tPort();
        summarize();
    end
endmodule

`default_nettype wire
